// ### scan_dac_cfg.svh
// Constants for the scan result to analog output converter control block.
// Assumes byte addressed classic Wishbone with a 32-bit data path.
// Summary of operation
// - Refresh every output after each monitor scan.
// - Log scan overrides a coinciding monitor scan.
// - Suppressed scan leaves previous outputs unchanged.
// - Convert upper, middle or lower digit group.
// - Ignore decimal point; digits form integer.
// - Never convert top digit of six.
// - Contact closed counts one, open zero.
// - Scale by (X-A)/B onto 999 span.
// - Up to twelve assigned channels; selective scan.
// - All-channel scan feeds assigned subset out.
// - Omitted fields default: lower digits, no offset.
// - Half-scale offset adds 500 before conversion.
// - Output sign follows input sign.
`ifndef SCAN_DAC_CFG_SVH
`define SCAN_DAC_CFG_SVH
`define CH_CNT 12
`define CODE_W 11
`define DIV_STEPS 5'd27
`define SCALE_MILLI 28'sd1000
`define HALF_SCALE 29'sd500
`define FULL_SPAN 29'sd999
`define GRP_LOWER 2'd0
`define GRP_MIDDLE 2'd1
`define GRP_UPPER 2'd2
`define REG_CTRL 7'h00
`define REG_STATUS 7'h01
`define REG_CFG_BASE 7'h10
`define REG_CODE_BASE 7'h40
`define CTRL_SEL_BIT 0
`define CTRL_CNT_LSB 4
`define CTRL_CNT_MSB 7
`define CTRL_MASK 32'h0000_00F1
`define CTRL_RESET 32'h0000_00C0
`define CFG_MASK 32'h0000_1FFF
`define CFG_RESET 32'h0000_0000
`define CFG_SRC_MSB 9
`define CFG_DSEL_LSB 10
`define CFG_DSEL_MSB 11
`define CFG_OFFS_BIT 12
`define SCALE_RESET 32'h03E8_0000
`define SCALE_B_LSB 16
`define CNT_MAX 4'd12
`endif

// ### scan_dac_output_control.sv
// Converter control: picks digit groups from scan results, scales and offsets them,
// and latches a bank of twelve signed output codes at the end of each monitor scan that no log scan overrides.
// Assumes a scan engine on the same clock and a classic Wishbone master.
`timescale 1ns/1ps
`include "scan_dac_cfg.svh"
module scan_dac_output_control (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire scan_dac_pkg::wb_req_type wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_valid_i,
	input wire scan_dac_pkg::sample_type sample_i,
	output logic sample_ready_o,
	input wire logic mon_done_i,
	input wire logic log_scan_i,
	output logic sel_scan_o,
	output logic dac_update_o,
	output scan_dac_pkg::code_bank_type dac_code_o
);
	import scan_dac_pkg::*;

	// Register file state.
	logic [31:0] ctrl_r, ctrl_nxt; // Scan mode and number of assigned channels.
	logic [31:0] cfg_r [`CH_CNT]; // Source channel, digit group, offset.
	logic [31:0] cfg_nxt [`CH_CNT];
	logic [31:0] scale_r [`CH_CNT]; // A in low half, B in thousandths in high half.
	logic [31:0] scale_nxt [`CH_CNT];
	logic ack_r, ack_nxt; // Bus acknowledge.
	logic [31:0] dat_r, dat_nxt; // Registered read data.
	logic [6:0] widx; // Word index of the bus address.
	logic [6:0] rel; // Index relative to the configuration block.

	// Processing state.
	proc_state_type state_r, state_nxt; // Sample processing state.
	logic [3:0] idx_r, idx_nxt; // Output channel being processed.
	logic signed [10:0] x_r, x_nxt; // Selected signed digital value.
	logic signed [27:0] num_r, num_nxt; // (X-A) times one thousand.
	logic start_r, start_nxt; // Divider start pulse.
	logic signed [27:0] q_r, q_nxt; // Scaled value from the divider.
	logic pend_r, pend_nxt; // A monitor scan ended and awaits the latch.
	logic ready_r, ready_nxt; // Sample handshake ready.
	logic upd_r, upd_nxt; // Output latch pulse.
	logic sel_r, sel_nxt; // Selective scan request to the engine.
	logic [7:0] upd_cnt_r, upd_cnt_nxt; // Count of output refreshes.
	logic [7:0] skip_cnt_r, skip_cnt_nxt; // Count of suppressed monitor scans.
	logic [`CODE_W-1:0] shadow_r [`CH_CNT]; // Codes gathered during the scan.
	logic [`CODE_W-1:0] shadow_nxt [`CH_CNT];
	code_bank_type code_r, code_nxt; // Codes on the converters.

	// Helpers.
	logic [`CH_CNT-1:0] hit; // Output channels assigned to the sample's source.
	logic [3:0] assigned; // Number of assigned channels, limited to twelve.
	logic accept; // A sample is taken this cycle.
	logic update_go; // Outputs latch this cycle.
	logic scaler_done; // Divider finished.
	logic signed [27:0] scaler_q; // Divider result.
	logic signed [28:0] sum; // Scaled value plus optional offset.
	logic [`CODE_W-1:0] store_val; // Clamped code for the shadow bank.
	logic [1:0] grp; // Digit group of the hit channel.
	logic [9:0] mag; // Three digit magnitude.
	logic signed [16:0] diff; // X minus A.

	assign widx = wb_i.adr[8:2];
	assign rel = 7'(widx - `REG_CFG_BASE);
	assign assigned = (ctrl_r[`CTRL_CNT_MSB:`CTRL_CNT_LSB] > `CNT_MAX) ? `CNT_MAX
		: ctrl_r[`CTRL_CNT_MSB:`CTRL_CNT_LSB];

	// Byte lane merge for writes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				res[b*8 +: 8] = nw[b*8 +: 8];
		return res & mask;
	endfunction

	// Three decimal digits of a BCD value starting at the given digit; the sixth
	// digit can never be reached because the highest start is the third digit.
	function automatic logic [9:0] digits3(input logic [23:0] bcd, input logic [1:0] g);
		logic [3:0] d0;
		logic [3:0] d1;
		logic [3:0] d2;
		logic [2:0] base;
		base = (g == `GRP_UPPER) ? 3'd2 : (g == `GRP_MIDDLE) ? 3'd1 : 3'd0;
		d0 = bcd[base*4 +: 4];
		d1 = bcd[(base+3'd1)*4 +: 4];
		d2 = bcd[(base+3'd2)*4 +: 4];
		return 10'(d2 * 10'd100 + d1 * 10'd10 + 10'(d0));
	endfunction

	// Which assigned output channels take this source channel.
	generate
		for (genvar k = 0; k < `CH_CNT; k++)
		begin : g_match
			assign hit[k] = (4'(k) < assigned)
				&& (cfg_r[k][`CFG_SRC_MSB:0] == sample_i.chan);
		end
	endgenerate

	// Register bus: one wait state, writes at the acknowledging edge, unmapped reads zero.
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		cfg_nxt = cfg_r;
		scale_nxt = scale_r;
		ack_nxt = wb_i.cyc && wb_i.stb && !ack_r;
		dat_nxt = '0;
		if (wb_i.cyc && wb_i.stb && !ack_r)
		begin
			// Read data is taken together with the acknowledge.
			if (widx == `REG_CTRL)
				dat_nxt = ctrl_r;
			else if (widx == `REG_STATUS)
				dat_nxt = {8'h00, skip_cnt_r, upd_cnt_r, 6'h00, pend_r, (state_r != ST_IDLE)};
			else if (widx >= `REG_CFG_BASE && rel < 7'(2 * `CH_CNT))
				dat_nxt = rel[0] ? scale_r[rel[4:1]] : cfg_r[rel[4:1]];
			else if (widx >= `REG_CODE_BASE && widx < 7'(`REG_CODE_BASE + `CH_CNT))
				dat_nxt = 32'($signed(code_r[4'(widx - `REG_CODE_BASE)]));
		end
		if (wb_i.cyc && wb_i.stb && wb_i.we && ack_r)
		begin
			// Writes land on the edge at which the master sees the acknowledge.
			if (widx == `REG_CTRL)
				ctrl_nxt = merge(ctrl_r, wb_i.dat, wb_i.sel, `CTRL_MASK);
			else if (widx >= `REG_CFG_BASE && rel < 7'(2 * `CH_CNT))
			begin
				if (rel[0])
					scale_nxt[rel[4:1]] = merge(scale_r[rel[4:1]], wb_i.dat, wb_i.sel, '1);
				else
					cfg_nxt[rel[4:1]] = merge(cfg_r[rel[4:1]], wb_i.dat, wb_i.sel, `CFG_MASK);
			end
		end
	end

	// Register the bus state; reset puts every channel at lower digits, no offset.
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			ctrl_r <= `CTRL_RESET;
			for (int k = 0; k < `CH_CNT; k++)
			begin
				cfg_r[k] <= `CFG_RESET;
				scale_r[k] <= `SCALE_RESET;
			end
			ack_r <= 1'b0;
			dat_r <= '0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			cfg_r <= cfg_nxt;
			scale_r <= scale_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	// Sequential (X-A)/B with B held in thousandths.
	value_scaler u_scaler (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.start_i(start_r),
		.num_i(num_r),
		.den_i(scale_r[idx_r][31:`SCALE_B_LSB]),
		.done_o(scaler_done),
		.quot_o(scaler_q)
	);

	assign accept = sample_valid_i && ready_r;
	// A monitor scan that meets a log scan is dropped at once; one that is clean
	// latches as soon as no sample is half processed.
	assign update_go = (state_r == ST_IDLE)
		&& (pend_r || (mon_done_i && !log_scan_i));

	// Sample processing, shadow bank and output latch.
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		x_nxt = x_r;
		num_nxt = num_r;
		start_nxt = 1'b0;
		q_nxt = q_r;
		pend_nxt = pend_r;
		shadow_nxt = shadow_r;
		code_nxt = code_r;
		upd_nxt = update_go;
		upd_cnt_nxt = upd_cnt_r;
		skip_cnt_nxt = skip_cnt_r;
		sel_nxt = ctrl_r[`CTRL_SEL_BIT];
		grp = `GRP_LOWER;
		mag = '0;
		diff = '0;
		sum = '0;
		store_val = '0;
		if (mon_done_i && log_scan_i)
			skip_cnt_nxt = 8'(skip_cnt_r + 8'd1);
		else if (mon_done_i && state_r != ST_IDLE)
			pend_nxt = 1'b1;
		if (update_go)
		begin
			// Every channel moves together from the gathered bank.
			for (int k = 0; k < `CH_CNT; k++)
				code_nxt[k] = shadow_r[k];
			pend_nxt = 1'b0;
			upd_cnt_nxt = 8'(upd_cnt_r + 8'd1);
		end
		case (state_r)
			ST_IDLE:
			begin
				// Samples taken during a log scan are not monitor data and are dropped.
				if (accept && !log_scan_i && (|hit))
				begin
					for (int k = `CH_CNT - 1; k >= 0; k--)
						if (hit[k])
							idx_nxt = 4'(k);
					grp = cfg_r[idx_nxt][`CFG_DSEL_MSB:`CFG_DSEL_LSB];
					mag = sample_i.contact ? {9'h000, sample_i.closed}
						: digits3(sample_i.bcd, grp);
					x_nxt = (sample_i.neg && !sample_i.contact) ? -$signed({1'b0, mag})
						: $signed({1'b0, mag});
					diff = 17'(x_nxt) - $signed(scale_r[idx_nxt][15:0]);
					num_nxt = 28'(diff) * `SCALE_MILLI;
					start_nxt = 1'b1;
					state_nxt = ST_DIV;
				end
			end
			ST_DIV:
			begin
				if (scaler_done)
				begin
					q_nxt = scaler_q;
					state_nxt = ST_STORE;
				end
			end
			ST_STORE:
			begin
				sum = 29'(q_r);
				if (cfg_r[idx_r][`CFG_OFFS_BIT])
					sum = sum + `HALF_SCALE;
				if (sum > `FULL_SPAN)
					store_val = `CODE_W'(`FULL_SPAN);
				else if (sum < -`FULL_SPAN)
					store_val = `CODE_W'(-`FULL_SPAN);
				else
					store_val = `CODE_W'(sum);
				shadow_nxt[idx_r] = store_val;
				state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		ready_nxt = (state_nxt == ST_IDLE);
	end

	// Register the processing state.
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			state_r <= ST_IDLE;
			idx_r <= '0;
			x_r <= '0;
			num_r <= '0;
			start_r <= 1'b0;
			q_r <= '0;
			pend_r <= 1'b0;
			ready_r <= 1'b0;
			upd_r <= 1'b0;
			sel_r <= 1'b0;
			upd_cnt_r <= '0;
			skip_cnt_r <= '0;
			for (int k = 0; k < `CH_CNT; k++)
				shadow_r[k] <= '0;
			code_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			x_r <= x_nxt;
			num_r <= num_nxt;
			start_r <= start_nxt;
			q_r <= q_nxt;
			pend_r <= pend_nxt;
			ready_r <= ready_nxt;
			upd_r <= upd_nxt;
			sel_r <= sel_nxt;
			upd_cnt_r <= upd_cnt_nxt;
			skip_cnt_r <= skip_cnt_nxt;
			shadow_r <= shadow_nxt;
			code_r <= code_nxt;
		end
	end

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign sample_ready_o = ready_r;
	assign sel_scan_o = sel_r;
	assign dac_update_o = upd_r;
	assign dac_code_o = code_r;

	// A clean monitor scan end refreshes the outputs within the processing time.
	refresh_after_scan_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		mon_done_i && !log_scan_i |-> ##[1:40] dac_update_o)
		else $error("Outputs not refreshed after monitor scan");
	// A monitor scan end during a log scan does not refresh the outputs.
	log_override_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		mon_done_i && log_scan_i && !pend_r && state_r == ST_IDLE |=> !dac_update_o)
		else $error("Monitor scan not suppressed by log scan");
	// Output codes only move on a refresh pulse.
	codes_held_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!dac_update_o |-> $stable(dac_code_o))
		else $error("Output codes changed without refresh");
	// The bank takes the shadow values all at once.
	bank_latch_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		update_go |=> dac_update_o && dac_code_o[0] == $past(shadow_r[0])
		&& dac_code_o[`CH_CNT-1] == $past(shadow_r[`CH_CNT-1]))
		else $error("Output bank not latched together");
	// A closed contact counts as one before scaling.
	contact_count_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		state_r == ST_IDLE && accept && !log_scan_i && (|hit) && sample_i.contact
		|=> x_r == 11'($past(sample_i.closed)) ##1 state_r == ST_DIV)
		else $error("Contact count wrong");
	// The selected value keeps the input sign and never exceeds three digits.
	sign_follow_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		state_r == ST_IDLE && accept && !log_scan_i && (|hit)
		|=> x_r <= 11'sd999 && x_r >= -11'sd999 && (x_r < 11'sd0)
		== ($past(sample_i.neg) && !$past(sample_i.contact) && x_r != 11'sd0))
		else $error("Selected value sign or range wrong");
	// Stored codes stay inside the full span.
	span_limit_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		state_r == ST_STORE |-> $signed(store_val) <= 11'sd999
		&& $signed(store_val) >= -11'sd999)
		else $error("Stored code outside full span");
	// With the offset on, a zero result becomes half scale.
	half_offset_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		state_r == ST_STORE && cfg_r[idx_r][`CFG_OFFS_BIT] && q_r == 28'sd0
		|=> shadow_r[$past(idx_r)] == 11'd500)
		else $error("Half scale offset not added");
	// Unassigned sources start no conversion.
	assigned_only_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		state_r == ST_IDLE && accept && !(|hit) |=> state_r == ST_IDLE && !start_r)
		else $error("Unassigned channel processed");
	// After reset channel zero selects the lower digits without offset.
	reset_default_a: assert property (@(posedge mclk_i)
		!nrst_i |=> cfg_r[0][`CFG_OFFS_BIT:`CFG_DSEL_LSB] == 3'b000)
		else $error("Channel defaults wrong after reset");
endmodule

// ### scan_dac_output_control_tb.sv
// Self-checking bench for the converter control block and a scan engine model.
// Assumes the design package and constants header are on the include path.
`timescale 1ns/1ps
module scan_dac_output_control_tb;
	import scan_dac_pkg::*;
	// One ordinary case: channel setup, scale, scan result and expected code.
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] scl;
		sample_type s;
		logic [10:0] exp;
	} row_type;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	wb_req_type wb = '0;
	logic [31:0] wb_dat;
	logic wb_ack;
	logic go = 1'b0;
	logic mon = 1'b0;
	logic log_scan = 1'b0;
	logic s_valid;
	logic s_ready;
	logic sel_scan;
	logic dac_upd;
	sample_type s_drv = '0;
	sample_type s_bus;
	code_bank_type codes;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] q;
	row_type rows [14];
	localparam logic [31:0] SC = 32'h03E8_0000;

	// The clock runs at 125 MHz.
	always #4 mclk = ~mclk;

	scan_dac_output_control dut_u (.mclk_i(mclk), .nrst_i(nrst), .wb_i(wb), .wb_dat_o(wb_dat),
		.wb_ack_o(wb_ack), .sample_valid_i(s_valid), .sample_i(s_bus), .sample_ready_o(s_ready),
		.mon_done_i(mon), .log_scan_i(log_scan), .sel_scan_o(sel_scan), .dac_update_o(dac_upd),
		.dac_code_o(codes));
	scan_engine_model eng_u (.mclk_i(mclk), .nrst_i(nrst), .send_i(go), .smp_i(s_drv),
		.ready_i(s_ready), .valid_o(s_valid), .smp_o(s_bus));

	// Builds a scan result from channel, sign and contact flags, and BCD digits.
	function automatic sample_type sm(input logic [9:0] c, input logic [2:0] f,
		input logic [23:0] b);
		return {c, f, b};
	endfunction

	// Builds a row for source channel zero.
	function automatic row_type r(input logic [31:0] c, input logic [31:0] s,
		input logic [2:0] f, input logic [23:0] b, input logic [10:0] e);
		return '{c, s, sm(10'h000, f, b), e};
	endfunction

	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
		begin
			$display("Testbench passed");
		end
		else
		begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Counts and reports one mismatch.
	task automatic fail(input string m);
		n_errors++;
		$display("BAD %0t %s", $time, m);
	endtask

	// Compares one value against its expectation.
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		cmp_count++;
		if (g !== e)
		begin
			fail(m);
		end
	endtask

	// One classic Wishbone cycle; read data lands in q at the acknowledging edge.
	task automatic wb_acc(input logic we, input logic [8:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wb <= '{1'b1, 1'b1, we, 4'hF, a, d};
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1)
		begin
			fail("no bus acknowledge");
			complete_run();
		end
		q = wb_dat;
		wb <= '0;
	endtask

	// Hands one result to the engine model and waits until it is taken.
	task automatic send(input sample_type s);
		int n;
		n = 0;
		@(posedge mclk);
		go <= 1'b1;
		s_drv <= s;
		@(posedge mclk);
		go <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (s_valid !== 1'b0 && n < 80);
		if (s_valid !== 1'b0)
		begin
			fail("sample never taken");
			complete_run();
		end
	endtask

	// Pulses the scan end; then expects an update within sixty cycles, or none for sixty cycles.
	task automatic mon_end(input logic want);
		int n;
		n = 0;
		@(posedge mclk);
		mon <= 1'b1;
		@(posedge mclk);
		mon <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
			if (!want)
			begin
				chk(dac_upd, 1'b0, "update during log scan");
			end
		end
		while ((!want || dac_upd !== 1'b1) && n < 60);
		if (want && dac_upd !== 1'b1)
		begin
			fail("no output update");
			complete_run();
		end
	endtask

	// Main sequence: reset, table of ordinary cases, then the awkward ones.
	initial
	begin
		rows[0] = r(32'h0, SC, 3'b000, 24'h987654, 11'h28E);
		rows[1] = r(32'h400, SC, 3'b000, 24'h987654, 11'h2FD);
		rows[2] = r(32'h800, SC, 3'b000, 24'h987654, 11'h36C);
		rows[3] = r(32'hC00, SC, 3'b000, 24'h987654, 11'h28E);
		rows[4] = r(32'h1000, SC, 3'b000, 24'h000123, 11'h26F);
		rows[5] = r(32'h0, SC, 3'b100, 24'h000321, 11'h6BF);
		rows[6] = r(32'h1000, SC, 3'b100, 24'h000800, 11'h6D4);
		rows[7] = r(32'h1000, SC, 3'b000, 24'h000700, 11'h3E7);
		rows[8] = r(32'h0, SC, 3'b011, 24'h000000, 11'h001);
		rows[9] = r(32'h0, SC, 3'b010, 24'h000000, 11'h000);
		rows[10] = r(32'h0, 32'h000A_0000, 3'b011, 24'h0, 11'h064);
		rows[11] = r(32'h0, 32'h0000_0000, 3'b011, 24'h0, 11'h3E7);
		rows[12] = r(32'h1000, SC, 3'b000, 24'h000000, 11'h1F4);
		rows[13] = r(32'h0, 32'h03E8_0064, 3'b000, 24'h000300, 11'h0C8);
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		wb_acc(1'b1, 9'h000, 32'h0000_00C0);
		foreach (rows[i])
		begin
			wb_acc(1'b1, 9'h040, rows[i].cfg);
			wb_acc(1'b1, 9'h044, rows[i].scl);
			send(rows[i].s);
			mon_end(1'b1);
			chk(codes[0], rows[i].exp, "output code");
			wb_acc(1'b0, 9'h100, 32'h0);
			chk(q, {{21{rows[i].exp[10]}}, rows[i].exp}, "code register");
		end
		// A log scan drops both the result and the coinciding scan end.
		log_scan <= 1'b1;
		send(sm(10'h000, 3'b000, 24'h000555));
		mon_end(1'b0);
		chk(codes[0], 11'h0C8, "held code changed");
		// Fourteen refreshes so far and one suppressed scan; nothing busy or pending.
		wb_acc(1'b0, 9'h004, 32'h0);
		chk(q, 32'h0001_0E00, "refresh and skip counts");
		log_scan <= 1'b0;
		mon_end(1'b1);
		chk(codes[0], 11'h0C8, "dropped sample used");
		// Two channels gather results and change together at the scan end.
		wb_acc(1'b1, 9'h000, 32'h0000_0021);
		// Channel zero goes back to unit scale with no zero shift.
		wb_acc(1'b1, 9'h044, SC);
		wb_acc(1'b1, 9'h048, 32'h0000_0007);
		send(sm(10'h007, 3'b000, 24'h000042));
		chk(sel_scan, 1'b1, "selective mode");
		send(sm(10'h000, 3'b000, 24'h000011));
		chk(codes[1], 11'h000, "early output change");
		mon_end(1'b1);
		chk(codes[0], 11'h00B, "first channel");
		chk(codes[1], 11'h02A, "second channel");
		// With one assigned channel, the second source is ignored.
		wb_acc(1'b1, 9'h000, 32'h0000_0010);
		send(sm(10'h007, 3'b000, 24'h000099));
		chk(sel_scan, 1'b0, "all-channel mode");
		send(sm(10'h000, 3'b000, 24'h000033));
		mon_end(1'b1);
		chk(codes[1], 11'h02A, "unassigned source used");
		chk(codes[0], 11'h021, "assigned source");
		// A second reset clears outputs and restores register defaults.
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(codes[0], 11'h000, "code after reset");
		chk(s_ready, 1'b0, "ready in reset");
		nrst <= 1'b1;
		wb_acc(1'b0, 9'h000, 32'h0);
		chk(q, 32'h0000_00C0, "control default");
		wb_acc(1'b0, 9'h044, 32'h0);
		chk(q, SC, "scale default");
		wb_acc(1'b0, 9'h040, 32'h0);
		chk(q, 32'h0, "setup default");
		wb_acc(1'b0, 9'h0FC, 32'h0);
		chk(q, 32'h0, "unmapped read");
		complete_run();
	end
endmodule

// ### scan_dac_pkg.sv
// Types shared by the converter control block and its scaler.
// Assumes the constants header is on the include path.
`include "scan_dac_cfg.svh"
package scan_dac_pkg;
	// One scan result from the scan engine.
	typedef struct packed {
		logic [9:0] chan;
		logic neg;
		logic contact;
		logic closed;
		logic [23:0] bcd;
	} sample_type;
	// Classic Wishbone request from the bus master.
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [8:0] adr;
		logic [31:0] dat;
	} wb_req_type;
	// Bank of signed output codes, one per analog channel.
	typedef logic [`CH_CNT-1:0][`CODE_W-1:0] code_bank_type;
	// Sample processing states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_STORE = 2'b10
	} proc_state_type;
endpackage

// ### scan_engine_model.sv
// Behavioural scan engine that hands scan results to the converter control block.
// Assumes the same clock and synchronous active-low reset as the block it feeds.
`timescale 1ns/1ps
module scan_engine_model
	import scan_dac_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic send_i,
	input wire scan_dac_pkg::sample_type smp_i,
	input wire logic ready_i,
	output logic valid_o,
	output scan_dac_pkg::sample_type smp_o
);
	// Offer one result, hold it until it is taken, then show a scrambled word.
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			valid_o <= 1'b0;
			smp_o <= '0;
		end
		else if (valid_o && ready_i)
		begin
			// Released data is inverted so that nothing reads a stale value.
			valid_o <= 1'b0;
			smp_o <= ~smp_o;
		end
		else if (send_i && !valid_o)
		begin
			valid_o <= 1'b1;
			smp_o <= smp_i;
		end
	end
endmodule

// ### value_scaler.sv
// Sequential signed divider that divides the scaled numerator by B in thousandths.
// Assumes start_i is a one-cycle pulse given only while the divider is idle.
`timescale 1ns/1ps
`include "scan_dac_cfg.svh"
module value_scaler (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic signed [27:0] num_i,
	input wire logic [15:0] den_i,
	output logic done_o,
	output logic signed [27:0] quot_o
);
	import scan_dac_pkg::*;
	logic busy_r, busy_nxt; // Division in progress.
	logic done_r, done_nxt; // Quotient valid pulse.
	logic neg_r, neg_nxt; // Sign of the result.
	logic [4:0] cnt_r, cnt_nxt; // Remaining steps.
	logic [15:0] rem_r, rem_nxt; // Partial remainder.
	logic [26:0] quo_r, quo_nxt; // Dividend shifting out, quotient shifting in.
	logic [15:0] den_r, den_nxt; // Held divisor.
	logic signed [27:0] res_r, res_nxt; // Signed result.
	logic [16:0] trial; // Remainder after one shift.
	logic [27:0] mag; // Numerator magnitude.

	// Restoring division, one quotient bit per cycle; a zero divisor saturates.
	always_comb
	begin
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		neg_nxt = neg_r;
		cnt_nxt = cnt_r;
		rem_nxt = rem_r;
		quo_nxt = quo_r;
		den_nxt = den_r;
		res_nxt = res_r;
		mag = num_i[27] ? 28'(-num_i) : 28'(num_i);
		trial = {rem_r, quo_r[26]};
		if (start_i)
		begin
			busy_nxt = 1'b1;
			neg_nxt = num_i[27];
			cnt_nxt = `DIV_STEPS;
			rem_nxt = '0;
			quo_nxt = mag[26:0];
			den_nxt = den_i;
		end
		else if (busy_r)
		begin
			// One restoring step.
			if (trial >= {1'b0, den_r})
			begin
				rem_nxt = 16'(trial - {1'b0, den_r});
				quo_nxt = {quo_r[25:0], 1'b1};
			end
			else
			begin
				rem_nxt = trial[15:0];
				quo_nxt = {quo_r[25:0], 1'b0};
			end
			cnt_nxt = 5'(cnt_r - 5'd1);
			if (cnt_r == 5'd1)
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				// A zero divisor gives the largest magnitude, which the caller clamps.
				if (den_r == 16'h0000)
					res_nxt = neg_r ? -28'sh7FFFFFF : 28'sh7FFFFFF;
				else
					res_nxt = neg_r ? -$signed({1'b0, quo_nxt}) : $signed({1'b0, quo_nxt});
			end
		end
	end

	// Register the divider state.
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			neg_r <= 1'b0;
			cnt_r <= '0;
			rem_r <= '0;
			quo_r <= '0;
			den_r <= '0;
			res_r <= '0;
		end
		else
		begin
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			neg_r <= neg_nxt;
			cnt_r <= cnt_nxt;
			rem_r <= rem_nxt;
			quo_r <= quo_nxt;
			den_r <= den_nxt;
			res_r <= res_nxt;
		end
	end

	assign done_o = done_r;
	assign quot_o = res_r;
endmodule
